/* File: rx_frame_check_pause_filter.sv */
// Purpose: receive frame checks, length limits and pause filter settings
// Assumes: 8-byte beats, first two beats hold the mac header fields
// Notes: beats wait eight stages so a runt or control drop precedes delivery
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "rx_check_regs.svh"
module rx_frame_check_pause_filter
    import rx_check_pkg::*;
#(
    parameter int LANES = `NUM_LANES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pcs lanes
    input wire logic lane_valid,
    input wire logic [LANES*66-1:0] lane_words,
    // receive beats from the mac core
    input wire logic rx_in_valid,
    input wire rx_beat_t rx_in,
    // client packet bus
    output logic rx_valid_out,
    output logic [63:0] rx_data_out,
    output logic [2:0] rx_mty_out,
    output logic rx_start_of_packet_out,
    output logic rx_end_of_packet_out,
    output logic rx_error_out,
    // statistics and classification
    output logic bad_fcs_stat,
    output logic good_frame_stat,
    output frame_class_t class_stat
);
    // settings registers
    logic [3:0] ctrl_q;
    logic [14:0] ceil_q;
    logic [7:0] floor_q;
    logic [15:0] spacing_q;
    logic [47:0] ucast_q, mcast_q, src_q;
    logic [15:0] gcp_low_q, gcp_high_q, pcp_low_q, pcp_high_q;
    logic [15:0] gcp_et_q, pcp_et_q, gpp_et_q, ppp_et_q;
    logic [15:0] gpp_op_q, ppp_op_q;
    logic [LANES*64-1:0] marker_q;
    logic [31:0] good_cnt_q;
    logic [LANES-1:0] locked;
    logic rx_rst;
    // marker defaults, lane 0 last
    localparam logic [64*20-1:0] MARKER_RST = {
        64'hc0f0e5003f0f1a00, 64'h5f662a00a099d500, 64'hadd6b70052294800,
        64'hc4314c003bceb300, 64'h3536cd00cac93200, 64'h83c7ca007c383500,
        64'h1af8bd00e5074200, 64'h5cb9b200a3464d00, 64'hb9915500466eaa00,
        64'hfd6c990002936600, 64'h68c9fb0097360400, 64'ha02476005fdb8900,
        64'h7b45660084ba9900, 64'h9a4a260065b5d900, 64'hdd14c20022eb3d00,
        64'hf50709000af8f600, 64'h4d957b00b26a8400, 64'h594be800a6b41700,
        64'h9d718e00628e7100, 64'hc16821003e97de00};

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // axi4-lite write: take address and data in either order
    logic aw_have_q, w_have_q;
    logic [11:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic wr_go;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 12'h000;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok(aw_q) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;

    function automatic logic wr_ok(input logic [11:0] a);
        return a <= `OFF_OPC_PP ||
            (a >= `OFF_MARK_BASE && a < `OFF_MARK_BASE + 12'(LANES*8));
    endfunction

    // settings storage; changes outside reset are honoured but unsafe
    logic [31:0] ctrl_m, len_m;
    assign ctrl_m = merge({28'h0, ctrl_q}, wd_q, ws_q);
    assign len_m = merge({8'h0, floor_q, 1'b0, ceil_q}, wd_q, ws_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 4'h0;
            ceil_q <= `LEN_CEIL_RST;
            floor_q <= `LEN_FLOOR_RST;
            spacing_q <= `SPACING_RST;
            ucast_q <= `UCAST_RST;
            mcast_q <= `MCAST_RST;
            src_q <= `SRC_RST;
            gcp_low_q <= `OPC_LOW_RST;
            gcp_high_q <= `OPC_HIGH_RST;
            pcp_low_q <= `OPC_LOW_RST;
            pcp_high_q <= `OPC_HIGH_RST;
            gcp_et_q <= `ETYPE_RST;
            pcp_et_q <= `ETYPE_RST;
            gpp_et_q <= `ETYPE_RST;
            ppp_et_q <= `ETYPE_RST;
            gpp_op_q <= `PAUSE_OPC_RST;
            ppp_op_q <= `PAUSE_OPC_RST;
            marker_q <= MARKER_RST[LANES*64-1:0];
        end else if (wr_go) begin
            case (aw_q)
                `OFF_CTRL: ctrl_q <= ctrl_m[3:0];
                `OFF_LEN: begin
                    ceil_q <= len_m[14:0];
                    floor_q <= len_m[23:16];
                end
                `OFF_SPACING: spacing_q <= wd_q[15:0];
                `OFF_UCAST_LO: ucast_q[31:0] <= wd_q;
                `OFF_UCAST_HI: ucast_q[47:32] <= wd_q[15:0];
                `OFF_MCAST_LO: mcast_q[31:0] <= wd_q;
                `OFF_MCAST_HI: mcast_q[47:32] <= wd_q[15:0];
                `OFF_SRC_LO: src_q[31:0] <= wd_q;
                `OFF_SRC_HI: src_q[47:32] <= wd_q[15:0];
                `OFF_GCP_OPC: {gcp_high_q, gcp_low_q} <= wd_q;
                `OFF_PCP_OPC: {pcp_high_q, pcp_low_q} <= wd_q;
                `OFF_ETYPE_CP: {pcp_et_q, gcp_et_q} <= wd_q;
                `OFF_ETYPE_PP: {ppp_et_q, gpp_et_q} <= wd_q;
                `OFF_OPC_PP: {ppp_op_q, gpp_op_q} <= wd_q;
                default: begin
                    if (wr_ok(aw_q))
                        marker_q[(aw_q - `OFF_MARK_BASE) * 8 +: 32] <= wd_q;
                end
            endcase
        end
    end
    assign rx_rst = !aresetn || ctrl_q[`CTRL_RX_RESET];

    // axi4-lite read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `OFF_CTRL: s_axi_rdata <= {28'h0, ctrl_q};
                `OFF_LEN: s_axi_rdata <= {8'h0, floor_q, 1'b0, ceil_q};
                `OFF_SPACING: s_axi_rdata <= {16'h0, spacing_q};
                `OFF_UCAST_LO: s_axi_rdata <= ucast_q[31:0];
                `OFF_UCAST_HI: s_axi_rdata <= {16'h0, ucast_q[47:32]};
                `OFF_MCAST_LO: s_axi_rdata <= mcast_q[31:0];
                `OFF_MCAST_HI: s_axi_rdata <= {16'h0, mcast_q[47:32]};
                `OFF_SRC_LO: s_axi_rdata <= src_q[31:0];
                `OFF_SRC_HI: s_axi_rdata <= {16'h0, src_q[47:32]};
                `OFF_GCP_OPC: s_axi_rdata <= {gcp_high_q, gcp_low_q};
                `OFF_PCP_OPC: s_axi_rdata <= {pcp_high_q, pcp_low_q};
                `OFF_ETYPE_CP: s_axi_rdata <= {pcp_et_q, gcp_et_q};
                `OFF_ETYPE_PP: s_axi_rdata <= {ppp_et_q, gpp_et_q};
                `OFF_OPC_PP: s_axi_rdata <= {ppp_op_q, gpp_op_q};
                `OFF_STATUS: s_axi_rdata <= 32'(locked);
                `OFF_GOOD_CNT: s_axi_rdata <= good_cnt_q;
                default: begin
                    if (wr_ok(s_axi_araddr)) begin
                        s_axi_rdata <= marker_q[(s_axi_araddr
                            - `OFF_MARK_BASE) * 8 +: 32];
                    end else begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    lane_marker_check #(.LANES(LANES)) u_marker (
        .aclk(aclk),
        .aresetn(!rx_rst),
        .spacing_less_one(spacing_q),
        .marker_values(marker_q),
        .lane_valid(lane_valid),
        .lane_words(lane_words),
        .lane_locked(locked)
    );

    // frame path: a runt has at most eight beats, all still in the line
    localparam int DEPTH = 8;
    frame_state_t state_q;
    client_beat_t pipe_q [DEPTH];
    frame_class_t pipe_cls_q [DEPTH];
    logic [DEPTH-1:0] pipe_v_q, pipe_bad_q, keep;
    logic [14:0] len_q, len_now;
    logic [47:0] dest_q, src_addr_q;
    frame_class_t cls, cls_q;
    logic [3:0] nbytes;
    assign nbytes = 4'd8 - {1'b0, rx_in.mty};
    assign len_now = (state_q == S_IDLE ? 15'h0000 : len_q) +
        {11'h0, nbytes};

    frame_classifier u_class (
        .dest(dest_q),
        .src({src_addr_q[47:32], rx_in.data[31:0]}),
        .ethertype(rx_in.data[63:48]),
        .opcode(rx_in.data[47:32]),
        .ucast(ucast_q),
        .mcast(mcast_q),
        .src_match(src_q),
        .check_src(ctrl_q[`CTRL_CHECK_SA]),
        .gcp_etype(gcp_et_q),
        .gcp_low(gcp_low_q),
        .gcp_high(gcp_high_q),
        .pcp_etype(pcp_et_q),
        .pcp_low(pcp_low_q),
        .pcp_high(pcp_high_q),
        .gpp_etype(gpp_et_q),
        .gpp_opcode(gpp_op_q),
        .ppp_etype(ppp_et_q),
        .ppp_opcode(ppp_op_q),
        .cls(cls)
    );

    logic is_ctrl, drop_ctrl, trunc, end_now, runt, take, kill;
    client_beat_t beat_in;
    assign is_ctrl = cls.gcp || cls.pcp || cls.gpp || cls.ppp;
    assign drop_ctrl = is_ctrl && !ctrl_q[`CTRL_FORWARD];
    assign trunc = len_now > ceil_q ||
        (len_now == ceil_q && !rx_in.eop);
    assign end_now = rx_in.eop || trunc;
    assign runt = end_now && len_now < `RUNT_BYTES;
    assign take = rx_in_valid && state_q != S_DROP &&
        (state_q != S_IDLE || rx_in.sop);
    assign kill = take && (runt || (state_q == S_HEAD && drop_ctrl));

    always_comb begin
        beat_in.data = rx_in.data;
        beat_in.mty = trunc ? 3'(len_now - ceil_q) + rx_in.mty :
            rx_in.mty;
        beat_in.sop = state_q == S_IDLE;
        beat_in.eop = end_now;
        beat_in.err = end_now && ((rx_in.eop && rx_in.fcs_bad &&
            !ctrl_q[`CTRL_SUPPRESS]) ||
            trunc ||
            len_now < {7'h0, floor_q});
    end

    // clear the killed frame back to its first beat, older frames stay
    always_comb begin
        logic open;
        open = kill;
        for (int k = 0; k < DEPTH; k++) begin
            keep[k] = !open;
            if (k == 0 ? beat_in.sop : pipe_q[k == 0 ? 0 : k - 1].sop)
                open = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (rx_rst) begin
            state_q <= S_IDLE;
            len_q <= 15'h0000;
            dest_q <= 48'h0;
            src_addr_q <= 48'h0;
            cls_q <= '0;
        end else if (take) begin
            len_q <= len_now;
            case (state_q)
                S_IDLE: begin
                    dest_q <= rx_in.data[63:16];
                    src_addr_q[47:32] <= rx_in.data[15:0];
                    state_q <= S_HEAD;
                end
                S_HEAD: begin
                    src_addr_q[31:0] <= rx_in.data[31:0];
                    cls_q <= cls;
                    state_q <= S_BODY;
                end
                default: state_q <= S_BODY;
            endcase
            if (kill || end_now)
                state_q <= (kill || trunc) && !rx_in.eop ? S_DROP : S_IDLE;
        end else if (rx_in_valid && state_q == S_DROP && rx_in.eop) begin
            state_q <= S_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (rx_rst) begin
            pipe_v_q <= '0;
            pipe_bad_q <= '0;
            for (int k = 0; k < DEPTH; k++) begin
                pipe_q[k] <= '0;
                pipe_cls_q[k] <= '0;
            end
        end else begin
            pipe_v_q <= {pipe_v_q[DEPTH-2:0], take} & keep;
            pipe_bad_q <= {pipe_bad_q[DEPTH-2:0],
                rx_in.eop && rx_in.fcs_bad};
            pipe_q[0] <= beat_in;
            pipe_cls_q[0] <= end_now ? cls_q : '0;
            for (int k = 1; k < DEPTH; k++) begin
                pipe_q[k] <= pipe_q[k-1];
                pipe_cls_q[k] <= pipe_cls_q[k-1];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (rx_rst) begin
            rx_valid_out <= 1'b0;
            rx_data_out <= 64'h0;
            rx_mty_out <= 3'h0;
            rx_start_of_packet_out <= 1'b0;
            rx_end_of_packet_out <= 1'b0;
            rx_error_out <= 1'b0;
            bad_fcs_stat <= 1'b0;
            good_frame_stat <= 1'b0;
            class_stat <= '0;
        end else begin
            rx_valid_out <= pipe_v_q[DEPTH-1];
            rx_data_out <= pipe_q[DEPTH-1].data;
            rx_mty_out <= pipe_q[DEPTH-1].mty;
            rx_start_of_packet_out <= pipe_v_q[DEPTH-1] &&
                pipe_q[DEPTH-1].sop;
            rx_end_of_packet_out <= pipe_v_q[DEPTH-1] &&
                pipe_q[DEPTH-1].eop;
            rx_error_out <= pipe_v_q[DEPTH-1] &&
                pipe_q[DEPTH-1].err;
            bad_fcs_stat <= pipe_v_q[DEPTH-1] &&
                pipe_bad_q[DEPTH-1];
            good_frame_stat <= pipe_v_q[DEPTH-1] &&
                pipe_q[DEPTH-1].eop;
            class_stat <= pipe_v_q[DEPTH-1] ? pipe_cls_q[DEPTH-1] : '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (rx_rst)
            good_cnt_q <= 32'h0;
        else if (good_frame_stat)
            good_cnt_q <= good_cnt_q + 32'h1;
    end
endmodule

/* File: rx_check_regs.svh */
// Purpose: offsets, field positions, reset values and limits for rx check
// Assumes: 32-bit axi4-lite register words, one aligned word each
// Notes: definitions only
`ifndef RX_CHECK_REGS_SVH
`define RX_CHECK_REGS_SVH

`define OFF_CTRL        12'h000
`define OFF_LEN         12'h004
`define OFF_SPACING     12'h008
`define OFF_UCAST_LO    12'h00c
`define OFF_UCAST_HI    12'h010
`define OFF_MCAST_LO    12'h014
`define OFF_MCAST_HI    12'h018
`define OFF_SRC_LO      12'h01c
`define OFF_SRC_HI      12'h020
`define OFF_GCP_OPC     12'h024
`define OFF_PCP_OPC     12'h028
`define OFF_ETYPE_CP    12'h02c
`define OFF_ETYPE_PP    12'h030
`define OFF_OPC_PP      12'h034
`define OFF_STATUS      12'h038
`define OFF_GOOD_CNT    12'h03c
`define OFF_MARK_BASE   12'h100

`define CTRL_SUPPRESS   0
`define CTRL_FORWARD    1
`define CTRL_CHECK_SA   2
`define CTRL_RX_RESET   3

`define LEN_CEIL_RST    15'h2580
`define LEN_FLOOR_RST   8'h40
`define SPACING_RST     16'h3fff
`define UCAST_RST       48'h000000000000
`define MCAST_RST       48'h0180c2000001
`define SRC_RST         48'h000000000000
`define OPC_LOW_RST     16'h0000
`define OPC_HIGH_RST    16'hffff
`define ETYPE_RST       16'h8808
`define PAUSE_OPC_RST   16'h0001
`define RUNT_BYTES      15'h0040
`define NUM_LANES       20

`endif

/* File: rx_check_pkg.sv */
// Purpose: shared types for the receive check block
// Assumes: nothing
// Notes: beat carries 8 bytes per transfer
package rx_check_pkg;
    typedef struct packed {
        logic [63:0] data;
        logic [2:0] mty;
        logic sop;
        logic eop;
        logic fcs_bad;
    } rx_beat_t;
    typedef struct packed {
        logic [63:0] data;
        logic [2:0] mty;
        logic sop;
        logic eop;
        logic err;
    } client_beat_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_HEAD = 2'b01,
        S_BODY = 2'b11,
        S_DROP = 2'b10
    } frame_state_t;
    typedef struct packed {
        logic gcp;
        logic pcp;
        logic gpp;
        logic ppp;
    } frame_class_t;
endpackage

/* File: lane_marker_check.sv */
// Purpose: alignment marker spacing and pattern check for each pcs lane
// Assumes: one lane word per lane per cycle when lane_valid is high
// Notes: a lane counts as locked once two markers land at the spacing
`timescale 1ns/1ns
`include "rx_check_regs.svh"
module lane_marker_check
    import rx_check_pkg::*;
#(
    parameter int LANES = 20
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // settings
    input wire logic [15:0] spacing_less_one,
    input wire logic [LANES*64-1:0] marker_values,
    // lane words
    input wire logic lane_valid,
    input wire logic [LANES*66-1:0] lane_words,
    // result
    output logic [LANES-1:0] lane_locked
);
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : lane
            logic [15:0] cnt_q;
            logic locked_q;
            logic hit;
            // sync header 10 then the 64-bit pattern
            assign hit = lane_words[g*66 +: 2] == 2'b10 &&
                lane_words[g*66+2 +: 64] == marker_values[g*64 +: 64];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_q <= 16'h0000;
                    locked_q <= 1'b0;
                end else if (lane_valid) begin
                    if (hit) begin
                        locked_q <= cnt_q == spacing_less_one;
                        cnt_q <= 16'h0000;
                    end else begin
                        if (cnt_q == spacing_less_one)
                            locked_q <= 1'b0;
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
            end
            assign lane_locked[g] = locked_q;
        end
    endgenerate
endmodule

/* File: frame_classifier.sv */
// Purpose: control and pause frame classification from header fields
// Assumes: fields valid when the caller samples cls
// Notes: purely combinational compare, the caller registers the result
`timescale 1ns/1ns
module frame_classifier
    import rx_check_pkg::*;
(
    // header fields
    input wire logic [47:0] dest,
    input wire logic [47:0] src,
    input wire logic [15:0] ethertype,
    input wire logic [15:0] opcode,
    // settings
    input wire logic [47:0] ucast,
    input wire logic [47:0] mcast,
    input wire logic [47:0] src_match,
    input wire logic check_src,
    input wire logic [15:0] gcp_etype,
    input wire logic [15:0] gcp_low,
    input wire logic [15:0] gcp_high,
    input wire logic [15:0] pcp_etype,
    input wire logic [15:0] pcp_low,
    input wire logic [15:0] pcp_high,
    input wire logic [15:0] gpp_etype,
    input wire logic [15:0] gpp_opcode,
    input wire logic [15:0] ppp_etype,
    input wire logic [15:0] ppp_opcode,
    // result
    output frame_class_t cls
);
    logic addr_ok;
    always_comb begin
        addr_ok = (dest == ucast || dest == mcast) &&
            (!check_src || src == src_match);
        cls.gcp = ethertype == gcp_etype &&
            opcode >= gcp_low && opcode <= gcp_high;
        cls.pcp = ethertype == pcp_etype &&
            opcode >= pcp_low && opcode <= pcp_high;
        cls.gpp = addr_ok && ethertype == gpp_etype &&
            opcode == gpp_opcode;
        cls.ppp = addr_ok && ethertype == ppp_etype &&
            opcode == ppp_opcode;
    end
endmodule

/* File: rx_check_assertions.sv */
// Purpose: port checks for the receive frame check block
// Assumes: one clock domain, settings unseen from the ports
// Notes: checks tie client outputs to the input end of frame
`timescale 1ns/1ns
module rx_check_assertions
    import rx_check_pkg::*;
(
    // clock and reset
    input wire logic aclk, aresetn,
    // receive input
    input wire logic rx_in_valid,
    input wire rx_beat_t rx_in,
    // client bus and statistics
    input wire logic rx_valid_out, rx_start_of_packet_out,
    input wire logic rx_end_of_packet_out, rx_error_out,
    input wire logic bad_fcs_stat, good_frame_stat,
    input wire frame_class_t class_stat,
    // register bus answers
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    eop_has_valid_a: assert property (rx_end_of_packet_out |-> rx_valid_out)
        else $error("end of packet without valid");
    err_on_end_a: assert property (rx_error_out |-> rx_end_of_packet_out)
        else $error("error outside the final beat");
    // truncation may end early, so only clean ends are tied to input
    clean_end_lag_a: assert property (rx_end_of_packet_out && !rx_error_out
        |-> $past(rx_in_valid && rx_in.eop, 9))
        else $error("final beat not nine cycles after input end");
    bad_fcs_lag_a: assert property (bad_fcs_stat
        |-> $past(rx_in_valid && rx_in.eop && rx_in.fcs_bad, 9))
        else $error("bad check statistic without cause");
    fcs_still_good_a: assert property (bad_fcs_stat && rx_end_of_packet_out
        |-> good_frame_stat)
        else $error("delivered bad check frame not counted good");
    class_on_end_a: assert property (|class_stat
        |-> $past(rx_in_valid && rx_in.eop, 9))
        else $error("class result away from frame end");
    sop_not_end_a: assert property (rx_start_of_packet_out
        |-> rx_valid_out && !rx_end_of_packet_out)
        else $error("single beat frame delivered");
    bresp_legal_a: assert property (s_axi_bvalid
        |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("write response code illegal");
endmodule
bind rx_frame_check_pause_filter rx_check_assertions u_rx_check_assertions (.*);

/* File: rx_client_sink.sv */
// Purpose: user receive logic on the client packet bus
// Assumes: beats arrive contiguous, sop first
// Notes: keeps only the last frame summary for the bench
`timescale 1ns/1ns
module rx_client_sink
    import rx_check_pkg::*;
(
    // client packet bus
    input wire logic aclk, rx_valid_out, rx_start_of_packet_out,
    input wire logic rx_end_of_packet_out, rx_error_out,
    input wire frame_class_t class_stat,
    // frame summary
    output int frames = 0,
    output logic last_err = '0,
    output logic [7:0] last_beats = '0,
    output frame_class_t last_cls = '0
);
    logic [7:0] beats_q = '0;
    logic [7:0] beats_d;
    // the client cannot stall the bus, so every beat is taken at once
    assign beats_d = rx_start_of_packet_out ? 8'h01 : beats_q + 8'h01;
    always_ff @(posedge aclk) begin
        if (rx_valid_out) begin
            beats_q <= beats_d;
            if (rx_end_of_packet_out) begin
                frames <= frames + 1;
                last_err <= rx_error_out;
                last_beats <= beats_d;
                last_cls <= class_stat;
            end
        end
    end
endmodule

/* File: rx_frame_check_pause_filter_bench.sv */
// Purpose: self-checking bench for the receive frame check block
// Assumes: bready and rready held high, client never stalls
// Notes: lanes stay idle, so marker lock is never seen, only marker settings
`timescale 1ns/1ns
`include "rx_check_regs.svh"
module rx_frame_check_pause_filter_bench
    import rx_check_pkg::*;
;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("unexpected %0t got %h want %h", $time, a, b); end end
    typedef struct {int len; logic bad; logic [3:0] ctl; logic [47:0] da;
        logic [31:0] eo; int df; logic err; frame_class_t cls;} row_t;
    logic aclk = '0, aresetn = '0, rx_in_valid = '0, lane_valid = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
    logic s_axi_bready = '1, s_axi_rready = '1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rx_valid_out, rx_start_of_packet_out, rx_error_out;
    logic rx_end_of_packet_out, bad_fcs_stat, good_frame_stat, last_err;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [20*66-1:0] lane_words = '0;
    logic [63:0] rx_data_out;
    logic [2:0] rx_mty_out;
    logic [7:0] last_beats;
    rx_beat_t rx_in = '0;
    frame_class_t class_stat, last_cls;
    int frames, failures = 0, checked = 0, n, exp_frames = 0;
    row_t rows[9] = '{
        '{64, 0, 0, 0, 32'h08000000, 1, 0, 4'h0},
        '{64, 1, 0, 0, 32'h08000000, 1, 1, 4'h0},
        '{64, 1, 1, 0, 32'h08000000, 1, 0, 4'h0},
        '{56, 0, 0, 0, 32'h08000000, 0, 0, 4'h0},
        '{64, 0, 2, 48'h0180c2000001, 32'h88080001, 1, 0, 4'hf},
        '{64, 0, 2, 48'h000000000000, 32'h88080001, 1, 0, 4'hf},
        '{64, 0, 2, 48'h0a0b0c0d0e0f, 32'h88080001, 1, 0, 4'hc},
        '{64, 0, 2, 48'h0180c2000001, 32'h88080002, 1, 0, 4'hc},
        '{64, 0, 0, 48'h0180c2000001, 32'h88080001, 0, 0, 4'hc}};
    rx_frame_check_pause_filter u_rx_frame_check_pause_filter (.*);
    rx_client_sink u_rx_client_sink (.*);
    initial begin
        forever #25 aclk = ~aclk;
    end
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        for (n = 0; n < 20 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end
        if (n == 20) begin failures++; wrap_up(); end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] d, m,
            input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= '1;
        for (n = 0; n < 20 && !s_axi_rvalid; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end
        if (n == 20) begin failures++; wrap_up(); end
        `CHK({s_axi_rresp, s_axi_rdata & m}, {r, d})
    endtask
    task automatic send(input int len, input logic bad, input logic [47:0] da,
            input logic [31:0] eo);
        for (int i = 0; i < (len + 7) / 8; i++) begin
            rx_in_valid <= '1;
            rx_in.data <= i == 0 ? {da, 16'h0000} : i == 1 ?
                {eo, 32'h00000000} : {8{i[7:0]}};
            rx_in.sop <= i == 0;
            rx_in.eop <= i == (len + 7) / 8 - 1;
            rx_in.mty <= 3'((8 - len % 8) % 8);
            rx_in.fcs_bad <= bad;
            @(posedge aclk);
        end
        rx_in_valid <= '0;
        repeat (11) @(posedge aclk);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= '1;
        foreach (rows[k]) begin
            wr(`OFF_CTRL, {28'h0000000, rows[k].ctl | 4'h8});
            wr(`OFF_CTRL, {28'h0000000, rows[k].ctl});
            send(rows[k].len, rows[k].bad, rows[k].da, rows[k].eo);
            exp_frames += rows[k].df;
            `CHK(frames, exp_frames)
            `CHK({last_err, last_cls}, {rows[k].err, rows[k].cls})
        end
        aresetn <= '0;
        repeat (10) @(posedge aclk);
        aresetn <= '1;
        rdc(`OFF_LEN, 32'h00402580, 32'h00ff7fff, 2'h0);
        rdc(`OFF_SPACING, 32'h00003fff, 32'h0000ffff, 2'h0);
        rdc(`OFF_MCAST_LO, 32'hc2000001, 32'hffffffff, 2'h0);
        rdc(`OFF_MARK_BASE, 32'h3e97de00, 32'hffffffff, 2'h0);
        rdc(`OFF_MARK_BASE + 12'h004, 32'hc1682100, '1, 2'h0);
        rdc(12'h0f0, 32'h00000000, 32'h00000000, 2'h2);
        wr(`OFF_CTRL, 32'h00000008);
        wr(`OFF_LEN, 32'h00400050);
        wr(`OFF_CTRL, 32'h00000000);
        send(96, 0, 0, 32'h08000000);
        `CHK({last_err, last_beats}, {1'h1, 8'h0a})
        wr(`OFF_CTRL, 32'h00000008);
        wr(`OFF_LEN, 32'h00482580);
        wr(`OFF_CTRL, 32'h00000000);
        send(64, 0, 0, 32'h08000000);
        `CHK({last_err, last_beats}, {1'h1, 8'h08})
        wrap_up();
    end
endmodule
